// file: rtl/instruction_sampling_monitor.sv
// instruction sampling monitor: fetch and op sampling halves with avalon slave
// How it works
// RULE_01: fetch counter steps once per completed fetch.
// RULE_02: op counter steps per cycle or per dispatched op, by mode.
// RULE_03: at fetch maximum, tag the next attempted fetch until done or abort.
// RULE_04: at op maximum, tag one op for monitoring.
// RULE_05: tagged fetch completing or aborting raises interrupt with sample.
// RULE_06: tagged op retiring raises interrupt, sample readable.
// RULE_07: events of tagged fetch or op are recorded for readout.
// RULE_08: fetch counter and fetch maximum are 20 bits wide.
// RULE_09: software writes upper 16 maximum bits; low 4 stay zero.
// RULE_10: fetch counter resets when it reaches the maximum.
// RULE_11: software may load the low 4 counter bits with random value.
// RULE_12: separate enables and registers; halves run alone or together.
// RULE_13: virtual fetch address always reported valid.
// RULE_14: physical valid flag only when address and page size valid.
// RULE_15: separate first-attempt miss flags for itlb levels and icache.
// RULE_16: completion flag set when delivered, clear on abort.
// RULE_17: two-bit itlb page size reported.
// RULE_18: latency counts cycles from fetch start to delivery or abort.
// RULE_19: sampled op reports address of its parent instruction.
// RULE_20: software writes maximum count, then sets enable.
// RULE_21: handler clears count and re-enables to arm the next sample.
// RULE_22: op counter is 27 bits, maximum low four bits zero.
// RULE_23: flushed tagged op drops sample, loads random count, retags later.
// RULE_24: no new fetch tag while a sample is outstanding.
`timescale 1ns/100ps
`default_nettype none
module instruction_sampling_monitor
   import sampling_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   // avalon-mm slave
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // fetch pipeline events
   input wire logic fetch_start_i,
   input wire logic [sampling_pkg::addr_width-1:0] fetch_vaddr_i,
   input wire logic fetch_complete_i,
   input wire logic fetch_abort_i,
   input wire logic fetch_translated_i,
   input wire logic [sampling_pkg::addr_width-1:0] fetch_paddr_i,
   input wire logic [sampling_pkg::page_size_width-1:0] fetch_page_size_i,
   input wire logic first_level_itlb_miss_i,
   input wire logic second_level_itlb_miss_i,
   input wire logic icache_miss_i,
   // op pipeline events
   input wire logic op_dispatch_i,
   input wire logic [sampling_pkg::addr_width-1:0] op_inst_addr_i,
   input wire logic op_tag_retire_i,
   input wire logic op_tag_flush_i,
   input wire logic [sampling_pkg::low_rand_width-1:0] random_i,
   output logic fetch_tag_o,
   output logic op_tag_o,
   output logic fetch_sample_irq_o,
   output logic op_sample_irq_o
);
   import sampling_pkg::*;

   // overview of the block:
   // two sampling halves share one state register and one bus slave
   // the fetch half counts completed fetches up to its maximum
   // once the maximum is met it arms and tags the next attempted fetch
   // the tagged fetch is tracked until it completes or aborts
   // its flags, addresses and latency then wait for the handler
   // the op half counts cycles or dispatched ops up to its maximum
   // a hit tags one op and captures its parent instruction address
   // a retired tagged op raises an interrupt, a flushed one is dropped
   // each half disarms itself after a sample until software re-enables
   // both halves may run alone or together, they never interact
   // limitation: only one fetch and one op sample can be outstanding

   // the whole state of the block in one packed word
   typedef struct packed {
      // fetch half: control, counter and sample fields
      fetch_state_type fstate;
      logic [fetch_cnt_width-1:0] fetch_cnt;
      logic [fetch_max_sw_width-1:0] fetch_max_hi;
      logic fetch_en;
      logic fetch_valid;
      logic fetch_completed_flag;
      logic phys_addr_valid_flag;
      logic first_level_itlb_miss_flag;
      logic second_level_itlb_miss_flag;
      logic icache_miss_flag;
      logic first_seen;
      logic [page_size_width-1:0] itlb_page_size_field;
      logic [lat_width-1:0] fetch_latency_count;
      logic [addr_width-1:0] fetch_va;
      logic [addr_width-1:0] fetch_pa;
      // op half: control, counter and sample fields
      op_state_type ostate;
      logic [op_cnt_width-1:0] op_cnt;
      logic [op_max_sw_width-1:0] op_max_hi;
      logic op_en;
      logic op_mode;
      logic op_valid;
      logic [addr_width-1:0] op_ia;
      // one-cycle interrupt pulses and bus answer
      logic fetch_irq;
      logic op_irq;
      logic [31:0] rdata;
      logic ack;
   } state_type;

   // current state and the value it takes at the next edge
   state_type cur;
   state_type next_cur;
   // helper nets derived from the current state and the inputs
   logic [fetch_cnt_width-1:0] fetch_max;
   logic [op_cnt_width-1:0] op_max;
   logic fetch_hit;
   logic op_hit;
   logic op_step;
   logic fetch_end;
   logic acc;

   // maxima carry hardwired zero low bits [RULE_08] [RULE_09] [RULE_22]
   assign fetch_max = {cur.fetch_max_hi, {low_rand_width{1'b0}}};
   assign op_max = {cur.op_max_hi, {low_rand_width{1'b0}}};
   // a hit needs the half to be enabled, so a stale count stays idle
   // equality only: software must not load a count above the maximum,
   // otherwise the counter runs the whole range before it hits
   assign fetch_hit = cur.fetch_en && (cur.fetch_cnt == fetch_max);
   assign op_hit = cur.op_en && (cur.op_cnt == op_max);
   // mode bit set counts dispatched ops, clear counts cycles [RULE_02]
   assign op_step = cur.op_mode ? op_dispatch_i : 1'b1;
   // either ending of a tagged fetch closes the sample
   assign fetch_end = fetch_complete_i || fetch_abort_i;
   // any bus access in progress
   assign acc = avs_read_i || avs_write_i;

   // one combinational pass computes the whole next state
   always_comb begin
      next_cur = cur;
      next_cur.fetch_irq = 1'b0;
      next_cur.op_irq = 1'b0;
      next_cur.ack = acc && !cur.ack;

      // fetch half
      // count: completed fetches step the counter toward the maximum
      // armed: waits for the next attempted fetch to tag it
      // track: collects flags and latency of the tagged fetch
      // done: sample held until software enables again
      case (cur.fstate)
         f_count: begin
            if (cur.fetch_en && fetch_complete_i) begin
               if (fetch_hit) begin
                  next_cur.fetch_cnt = '0; // [RULE_10]
                  next_cur.fstate = f_armed; // [RULE_03]
               end else begin
                  next_cur.fetch_cnt = cur.fetch_cnt + 1'b1; // [RULE_01]
               end
            end else if (fetch_hit) begin
               next_cur.fetch_cnt = '0; // [RULE_10]
               next_cur.fstate = f_armed; // [RULE_03]
            end
         end
         f_armed: begin
            // the next attempted fetch carries the tag [RULE_03]
            // the flags, latency and virtual address restart here, so an old sample never
            // leaks flags into the new one; fetch_pa and the page size field are kept
            if (fetch_start_i) begin
               next_cur.fstate = f_track;
               next_cur.fetch_va = fetch_vaddr_i; // [RULE_13]
               next_cur.fetch_latency_count = '0;
               next_cur.first_seen = 1'b0;
               next_cur.phys_addr_valid_flag = 1'b0;
               next_cur.first_level_itlb_miss_flag = 1'b0;
               next_cur.second_level_itlb_miss_flag = 1'b0;
               next_cur.icache_miss_flag = 1'b0;
               next_cur.fetch_completed_flag = 1'b0;
            end
         end
         f_track: begin
            // saturating so a stuck fetch cannot wrap the figure
            if (cur.fetch_latency_count != '1) begin
               next_cur.fetch_latency_count =
                  cur.fetch_latency_count + 1'b1; // [RULE_18]
            end
            // only the first translation attempt is recorded [RULE_15]
            if (fetch_translated_i && !cur.first_seen) begin
               next_cur.first_seen = 1'b1;
               next_cur.first_level_itlb_miss_flag =
                  first_level_itlb_miss_i; // [RULE_07]
               next_cur.second_level_itlb_miss_flag =
                  second_level_itlb_miss_i;
               next_cur.icache_miss_flag = icache_miss_i;
               next_cur.fetch_pa = fetch_paddr_i;
               next_cur.itlb_page_size_field = fetch_page_size_i; // [RULE_17]
               next_cur.phys_addr_valid_flag = 1'b1; // [RULE_14]
            end
            // the ending cycle is counted in the latency as well
            // a fetch killed before translation keeps phys valid clear
            if (fetch_end) begin
               next_cur.fetch_completed_flag = fetch_complete_i; // [RULE_16]
               next_cur.fetch_valid = 1'b1;
               next_cur.fetch_en = 1'b0; // [RULE_24]
               next_cur.fetch_irq = 1'b1; // [RULE_05]
               next_cur.fstate = f_done;
            end
         end
         f_done: begin
            // held until software re-enables [RULE_24]
            if (cur.fetch_en) begin
               next_cur.fstate = f_count;
            end
         end
         default: next_cur.fstate = f_count;
      endcase

      // op half, independent of the fetch half [RULE_12]
      // count: cycles or dispatches step the counter toward the maximum
      // track: the tagged op is in flight, waiting to retire or flush
      // done: sample held until software enables again
      // the address is taken in the hit cycle, with the tagged op
      case (cur.ostate)
         o_count: begin
            if (op_hit) begin
               next_cur.ostate = o_track; // [RULE_04]
               next_cur.op_cnt = '0;
               next_cur.op_ia = op_inst_addr_i; // [RULE_19]
            end else if (cur.op_en && op_step) begin
               next_cur.op_cnt = cur.op_cnt + 1'b1; // [RULE_02]
            end
         end
         o_track: begin
            // a flush beats a retire in the same cycle: no sample then
            if (op_tag_flush_i) begin
               // sample dropped and counting restarts randomised [RULE_23]
               next_cur.op_cnt = {{(op_cnt_width-low_rand_width){1'b0}},
                  random_i};
               next_cur.ostate = o_count;
            end else if (op_tag_retire_i) begin
               next_cur.op_valid = 1'b1;
               next_cur.op_en = 1'b0;
               next_cur.op_irq = 1'b1; // [RULE_06]
               next_cur.ostate = o_done;
            end
         end
         o_done: begin
            // held until software re-enables
            if (cur.op_en) begin
               next_cur.ostate = o_count;
            end
         end
         default: next_cur.ostate = o_count;
      endcase

      // register writes land on the edge where waitrequest is low
      // they come after the halves, so a software counter write wins
      // over a hardware step in the same cycle
      // a valid flag being set in this cycle is not cleared by a
      // re-enable, so a finished sample is never lost
      if (avs_write_i && cur.ack) begin
         if (avs_address_i == fetch_ctl_off) begin
            next_cur.fetch_max_hi = avs_writedata_i[ctl_max_lsb +:
               fetch_max_sw_width]; // [RULE_09] [RULE_20]
            next_cur.fetch_en = avs_writedata_i[ctl_enable_bit]; // [RULE_12]
            if (avs_writedata_i[ctl_enable_bit] &&
                  !(cur.fstate == f_track && fetch_end)) begin
               next_cur.fetch_valid = 1'b0; // [RULE_21]
            end
         end else if (avs_address_i == fetch_cnt_off) begin
            // low bits may take a random seed [RULE_11]
            next_cur.fetch_cnt = avs_writedata_i[fetch_cnt_width-1:0];
         end else if (avs_address_i == op_ctl_off) begin
            next_cur.op_max_hi = avs_writedata_i[ctl_max_lsb +:
               op_max_sw_width]; // [RULE_22]
            next_cur.op_en = avs_writedata_i[ctl_enable_bit]; // [RULE_12]
            next_cur.op_mode = avs_writedata_i[ctl_mode_bit];
            if (avs_writedata_i[ctl_enable_bit] &&
                  !(cur.ostate == o_track && op_tag_retire_i &&
                  !op_tag_flush_i)) begin
               next_cur.op_valid = 1'b0;
            end
         end else if (avs_address_i == op_cnt_off) begin
            next_cur.op_cnt = avs_writedata_i[op_cnt_width-1:0];
         end
      end

      // read data captured for the acknowledging cycle
      // taken one cycle early, so the answer comes from a flop and
      // the address decode stays off the output path
      // unmapped addresses and unused bits read as zero
      next_cur.rdata = unmapped_value;
      if (avs_read_i && !cur.ack) begin
         if (avs_address_i == fetch_ctl_off) begin
            next_cur.rdata[ctl_max_lsb +: fetch_max_sw_width] =
               cur.fetch_max_hi;
            next_cur.rdata[ctl_enable_bit] = cur.fetch_en;
         end else if (avs_address_i == fetch_cnt_off) begin
            next_cur.rdata[fetch_cnt_width-1:0] = cur.fetch_cnt;
         end else if (avs_address_i == fetch_stat_off) begin
            next_cur.rdata[st_valid_bit] = cur.fetch_valid;
            next_cur.rdata[st_comp_bit] = cur.fetch_completed_flag;
            next_cur.rdata[st_phys_bit] = cur.phys_addr_valid_flag;
            next_cur.rdata[st_l1_bit] = cur.first_level_itlb_miss_flag;
            next_cur.rdata[st_l2_bit] = cur.second_level_itlb_miss_flag;
            next_cur.rdata[st_ic_bit] = cur.icache_miss_flag;
            next_cur.rdata[st_pg_lsb +: page_size_width] =
               cur.itlb_page_size_field;
            next_cur.rdata[st_lat_lsb +: lat_width] =
               cur.fetch_latency_count;
         end else if (avs_address_i == fetch_va_lo_off) begin
            next_cur.rdata = cur.fetch_va[31:0];
         end else if (avs_address_i == fetch_va_hi_off) begin
            next_cur.rdata[addr_width-33:0] = cur.fetch_va[addr_width-1:32];
         end else if (avs_address_i == fetch_pa_lo_off) begin
            next_cur.rdata = cur.fetch_pa[31:0];
         end else if (avs_address_i == fetch_pa_hi_off) begin
            next_cur.rdata[addr_width-33:0] = cur.fetch_pa[addr_width-1:32];
         end else if (avs_address_i == op_ctl_off) begin
            next_cur.rdata[ctl_max_lsb +: op_max_sw_width] = cur.op_max_hi;
            next_cur.rdata[ctl_enable_bit] = cur.op_en;
            next_cur.rdata[ctl_mode_bit] = cur.op_mode;
         end else if (avs_address_i == op_cnt_off) begin
            next_cur.rdata[op_cnt_width-1:0] = cur.op_cnt;
         end else if (avs_address_i == op_stat_off) begin
            next_cur.rdata[st_valid_bit] = cur.op_valid;
         end else if (avs_address_i == op_ia_lo_off) begin
            next_cur.rdata = cur.op_ia[31:0];
         end else if (avs_address_i == op_ia_hi_off) begin
            next_cur.rdata[addr_width-33:0] = cur.op_ia[addr_width-1:32];
         end
      end
   end

   // single state register, constant reset values
   // reset leaves both halves disabled and idle
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   // one wait cycle per access keeps decode off the answer path
   // a request held after an answer starts the next access, with its own wait cycle
   assign avs_waitrequest_o = acc && !cur.ack;
   assign avs_readdata_o = cur.rdata;
   // tags are combinational so the pipeline marks the very fetch or op
   // that is in the stage in this cycle
   assign fetch_tag_o = (cur.fstate == f_armed) && fetch_start_i;
   assign op_tag_o = (cur.ostate == o_count) && op_hit;
   // interrupt pulses come straight from the state register
   assign fetch_sample_irq_o = cur.fetch_irq;
   assign op_sample_irq_o = cur.op_irq;
endmodule
`default_nettype wire

// file: rtl/sampling_pkg.sv
// shared constants for the instruction sampling monitor
package sampling_pkg;
   localparam int fetch_cnt_width = 20;
   localparam int fetch_max_sw_width = 16;
   localparam int op_cnt_width = 27;
   localparam int op_max_sw_width = 23;
   localparam int low_rand_width = 4;
   localparam int addr_width = 48;
   localparam int lat_width = 16;
   localparam int page_size_width = 2;
   // register byte offsets
   localparam logic [7:0] fetch_ctl_off = 8'h00;
   localparam logic [7:0] fetch_cnt_off = 8'h04;
   localparam logic [7:0] fetch_stat_off = 8'h08;
   localparam logic [7:0] fetch_va_lo_off = 8'h0C;
   localparam logic [7:0] fetch_va_hi_off = 8'h10;
   localparam logic [7:0] fetch_pa_lo_off = 8'h14;
   localparam logic [7:0] fetch_pa_hi_off = 8'h18;
   localparam logic [7:0] op_ctl_off = 8'h20;
   localparam logic [7:0] op_cnt_off = 8'h24;
   localparam logic [7:0] op_stat_off = 8'h28;
   localparam logic [7:0] op_ia_lo_off = 8'h2C;
   localparam logic [7:0] op_ia_hi_off = 8'h30;
   // control field positions
   localparam int ctl_max_lsb = 0;
   localparam int ctl_enable_bit = 24;
   localparam int ctl_mode_bit = 25;
   // fetch status field positions
   localparam int st_valid_bit = 0;
   localparam int st_comp_bit = 1;
   localparam int st_phys_bit = 2;
   localparam int st_l1_bit = 3;
   localparam int st_l2_bit = 4;
   localparam int st_ic_bit = 5;
   localparam int st_pg_lsb = 6;
   localparam int st_lat_lsb = 16;
   localparam logic [31:0] unmapped_value = 32'h0000_0000;
   typedef enum logic [1:0] {
      f_count = 2'b00,
      f_armed = 2'b01,
      f_track = 2'b10,
      f_done = 2'b11
   } fetch_state_type;
   typedef enum logic [1:0] {
      o_count = 2'b00,
      o_track = 2'b01,
      o_done = 2'b10
   } op_state_type;
endpackage

// file: verification/instruction_sampling_monitor_checker.sv
// port assertions for the instruction sampling monitor
`timescale 1ns/100ps
`default_nettype none
module instruction_sampling_monitor_checker
   import sampling_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic avs_waitrequest_o,
   input wire logic fetch_start_i,
   input wire logic fetch_complete_i,
   input wire logic fetch_abort_i,
   input wire logic op_tag_retire_i,
   input wire logic fetch_tag_o,
   input wire logic fetch_sample_irq_o,
   input wire logic op_sample_irq_o
);
   logic busy; // a fetch sample waits for software to re-arm
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   // only a taken fetch control write re-arms, so a tag before it is a retag
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) busy <= 1'b0;
      else if (fetch_tag_o) busy <= 1'b1;
      else if (avs_write_i && !avs_waitrequest_o &&
               avs_address_i == fetch_ctl_off) busy <= 1'b0;
   end
   a_wait_first_cycle: assert property (
      $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
      else $error("no wait state in first access cycle");
   a_wait_one_cycle: assert property (
      ((avs_read_i || avs_write_i) && avs_waitrequest_o) ##1
      (avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
      else $error("access not answered after one wait cycle");
   a_fetch_irq_pulse: assert property (
      fetch_sample_irq_o |=> !fetch_sample_irq_o)
      else $error("fetch interrupt longer than one cycle");
   a_fetch_irq_cause: assert property (
      fetch_sample_irq_o |-> $past(fetch_complete_i || fetch_abort_i))
      else $error("fetch interrupt without completion or abort");
   a_op_irq_pulse: assert property (
      op_sample_irq_o |=> !op_sample_irq_o)
      else $error("op interrupt longer than one cycle");
   a_op_irq_cause: assert property (
      op_sample_irq_o |-> $past(op_tag_retire_i))
      else $error("op interrupt without retirement");
   a_tag_on_start: assert property (
      fetch_tag_o |-> fetch_start_i)
      else $error("fetch tag without an attempted fetch");
   a_no_fetch_retag: assert property (
      fetch_tag_o |-> !busy)
      else $error("fetch tagged while a sample is outstanding");
endmodule
bind instruction_sampling_monitor instruction_sampling_monitor_checker
   i_checker (.ref_clk_i, .rst_b_i, .avs_address_i, .avs_read_i,
   .avs_write_i, .avs_waitrequest_o, .fetch_start_i, .fetch_complete_i,
   .fetch_abort_i, .op_tag_retire_i, .fetch_tag_o, .fetch_sample_irq_o,
   .op_sample_irq_o);
`default_nettype wire

// file: verification/instruction_sampling_monitor_tb_top.sv
// self-checking bench for the instruction sampling monitor
`timescale 1ns/100ps
`default_nettype none
module instruction_sampling_monitor_tb_top;
   import sampling_pkg::*;
   typedef struct {string name; logic [31:0] exp;} note_type;
   logic ref_clk_i = 1'b0, rst_b_i = 1'b0, avs_read_i = 1'b0;
   logic avs_write_i = 1'b0, avs_waitrequest_o, tag_seen;
   logic [7:0] avs_address_i = 8'h00;
   logic [31:0] avs_writedata_i = 32'h0000_0000, avs_readdata_o;
   logic [6:0] ev = 7'h00; // complete abort start xlat dispatch retire flush
   logic [4:0] tr = 5'h00; // itlb l1, l2, icache misses, then page size
   logic [47:0] fetch_vaddr_i = 48'h0000_0000_0000;
   logic [47:0] fetch_paddr_i = 48'h0000_0000_0000;
   logic [47:0] op_inst_addr_i = 48'h0000_0000_0000;
   logic [3:0] random_i = 4'h0;
   logic [15:0] m;
   logic fetch_tag_o, op_tag_o, fetch_sample_irq_o, op_sample_irq_o;
   note_type notes[$];
   note_type nt;
   int mismatches = 0, cmp_count = 0, fetch_irqs = 0, op_irqs = 0, op_tags = 0;

   instruction_sampling_monitor i_instruction_sampling_monitor (
      .ref_clk_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
      .fetch_start_i(ev[2]), .fetch_vaddr_i, .fetch_complete_i(ev[0]),
      .fetch_abort_i(ev[1]), .fetch_translated_i(ev[3]), .fetch_paddr_i,
      .fetch_page_size_i(tr[4:3]), .first_level_itlb_miss_i(tr[0]),
      .second_level_itlb_miss_i(tr[1]), .icache_miss_i(tr[2]),
      .op_dispatch_i(ev[4]), .op_inst_addr_i, .op_tag_retire_i(ev[5]),
      .op_tag_flush_i(ev[6]), .random_i, .fetch_tag_o, .op_tag_o,
      .fetch_sample_irq_o, .op_sample_irq_o);

   always #2.5 ref_clk_i = ~ref_clk_i;

   // watcher on the falling edge, where every output has settled
   always @(negedge ref_clk_i) begin
      if (avs_read_i && avs_waitrequest_o === 1'b0) begin
         nt = notes.pop_front();
         chk(nt.name, nt.exp, avs_readdata_o);
      end
      fetch_irqs += (fetch_sample_irq_o === 1'b1);
      op_irqs += (op_sample_irq_o === 1'b1);
      op_tags += (op_tag_o === 1'b1);
   end

   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", s, e, g);
      end
   endtask

   // one avalon access, held until waitrequest is seen low at an edge
   task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      avs_address_i <= a;
      avs_read_i <= rd;
      avs_write_i <= !rd;
      avs_writedata_i <= d;
      @(negedge ref_clk_i);
      while (avs_waitrequest_o !== 1'b0) begin
         n++;
         if (n > 50) begin
            mismatches++;
            finish_test();
         end
         @(negedge ref_clk_i);
      end
      @(posedge ref_clk_i);
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask

   task automatic rd(input string s, input logic [7:0] a, input logic [31:0] e);
      notes.push_back('{s, e});
      bus(1'b1, a, 32'h0000_0000);
   endtask

   // one-cycle event; the combinational fetch tag is looked at mid-pulse
   task automatic strobe(input int s);
      @(posedge ref_clk_i);
      ev[s] <= 1'b1;
      @(negedge ref_clk_i);
      tag_seen = fetch_tag_o;
      @(posedge ref_clk_i);
      ev[s] <= 1'b0;
   endtask

   // strobes are two cycles apart, so latency is six plus the extra wait
   task automatic fetch_run(input logic comp);
      logic [3:0] r;
      logic [31:0] e;
      int x, k;
      fetch_vaddr_i <= 48'({$urandom(), $urandom()});
      fetch_paddr_i <= 48'({$urandom(), $urandom()});
      tr <= 5'($urandom());
      r = 4'($urandom());
      x = $urandom_range(4, 0);
      k = fetch_irqs;
      bus(1'b0, fetch_cnt_off, {28'h000_0000, r});
      bus(1'b0, fetch_ctl_off, 32'h0100_0001);
      repeat (15 - r) strobe(0);
      rd("fcnt", fetch_cnt_off, 32'h0000_000F);
      strobe(0);
      rd("fcnt wrap", fetch_cnt_off, 32'h0000_0000);
      strobe(2);
      chk("ftag", 32'h0000_0001, 32'(tag_seen));
      strobe(3);
      strobe(2);
      chk("ftag again", 32'h0000_0000, 32'(tag_seen));
      repeat (x) @(posedge ref_clk_i);
      strobe(comp ? 0 : 1);
      e = {16'(6 + x), 8'h00, tr[4:3], tr[2:0], 1'b1, comp, 1'b1};
      rd("fstat", fetch_stat_off, e);
      rd("va lo", fetch_va_lo_off, fetch_vaddr_i[31:0]);
      rd("va hi", fetch_va_hi_off, {16'h0000, fetch_vaddr_i[47:32]});
      rd("pa lo", fetch_pa_lo_off, fetch_paddr_i[31:0]);
      rd("pa hi", fetch_pa_hi_off, {16'h0000, fetch_paddr_i[47:32]});
      chk("firq", 32'(k + 1), 32'(fetch_irqs));
      strobe(2);
      chk("ftag disarmed", 32'h0000_0000, 32'(tag_seen));
   endtask

   // bounded wait for an op tag, feeding dispatches in dispatch mode
   task automatic op_wait(input logic mode);
      int n, k;
      n = op_tags;
      k = 0;
      while (op_tags == n && k < 40) begin
         k++;
         if (mode) strobe(4);
         else @(posedge ref_clk_i);
      end
      chk("otag", 32'(n + 1), 32'(op_tags));
   endtask

   task automatic op_run(input logic mode);
      int k;
      k = op_irqs;
      op_inst_addr_i <= 48'({$urandom(), $urandom()});
      random_i <= 4'($urandom());
      bus(1'b0, op_cnt_off, 32'h0000_0000);
      bus(1'b0, op_ctl_off, {6'h00, mode, 1'b1, 24'h00_0001});
      if (mode) begin
         repeat (15) strobe(4);
         rd("ocnt", op_cnt_off, 32'h0000_000F);
         op_wait(mode);
         strobe(6);
         rd("ocnt flush", op_cnt_off, {28'h000_0000, random_i});
      end
      op_wait(mode);
      strobe(5);
      rd("ostat", op_stat_off, 32'h0000_0001);
      rd("ia lo", op_ia_lo_off, op_inst_addr_i[31:0]);
      rd("ia hi", op_ia_hi_off, {16'h0000, op_inst_addr_i[47:32]});
      chk("oirq", 32'(k + 1), 32'(op_irqs));
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // reset values, field widths, then both sampling halves
   initial begin
      void'($urandom(32'h7676));
      m = 16'($urandom());
      repeat (6) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      rd("fctl", fetch_ctl_off, 32'h0000_0000);
      rd("octl", op_ctl_off, 32'h0000_0000);
      bus(1'b0, 8'hFC, 32'hFFFF_FFFF);
      rd("unmapped", 8'hFC, unmapped_value);
      bus(1'b0, fetch_ctl_off, {8'h00, 8'hFF, m});
      rd("fmax", fetch_ctl_off, {16'h0000, m});
      bus(1'b0, fetch_cnt_off, 32'hFFFF_FFFF);
      rd("fcnt width", fetch_cnt_off, 32'h000F_FFFF);
      bus(1'b0, op_cnt_off, 32'hFFFF_FFFF);
      rd("ocnt width", op_cnt_off, 32'h07FF_FFFF);
      bus(1'b0, op_ctl_off, 32'h00FF_FFFF);
      rd("omax", op_ctl_off, 32'h007F_FFFF);
      $display("test registers done");
      fetch_run(1'b1);
      fetch_run(1'b0);
      $display("test fetch done");
      op_run(1'b1);
      op_run(1'b0);
      $display("test op done");
      finish_test();
   end

   // the run needs under two thousand cycles; this cuts a hang short
   initial begin
      #50000;
      mismatches++;
      finish_test();
   end
endmodule
`default_nettype wire
